// ===== cpuox_params.svh
// Constants for the operand decode and byte transfer executor
`ifndef CPUOX_PARAMS_SVH
`define CPUOX_PARAMS_SVH
`define CPUOX_SADDR_LO      16'hFE20
`define CPUOX_SADDR_HI      16'hFF1F
`define CPUOX_SFR_BASE      16'hFF00
`define CPUOX_SFR_HOLE_LO   16'hFFD0
`define CPUOX_SFR_HOLE_HI   16'hFFDF
`define CPUOX_CALLF_LO      16'h0800
`define CPUOX_CALLF_HI      16'h0FFF
`define CPUOX_CALLT_LO      16'h0040
`define CPUOX_CALLT_HI      16'h007F
`define CPUOX_FASTRAM_LO    16'hFB00
`define CPUOX_FASTRAM_HI    16'hFEFF
`define CPUOX_PSW_RESET     8'h02
`define CPUOX_PSW_Z_BIT     6
`define CPUOX_PSW_AC_BIT    4
`define CPUOX_PSW_CY_BIT    0
`define CPUOX_CLK_REG2      5'h02
`define CPUOX_CLK_IMM       5'h04
`define CPUOX_CLK_MEM_FAST  5'h04
`define CPUOX_CLK_MEM_SLOW  5'h05
`define CPUOX_CLK_IDX_FAST  5'h08
`define CPUOX_CLK_IDX_SLOW  5'h09
`define CPUOX_CLK_XIDX_SLOW 5'h0A
`define CPUOX_CLK_XMEM_SLOW 5'h06
`define CPUOX_CLK_SFR_IMM   5'h07
`define CPUOX_CLK_SFR_ACC   5'h05
`define CPUOX_BYTES_IDX     3'h2
`endif

// ===== cpuox_pkg.sv
// Types shared by the executor and its testbench
package cpuox_pkg;
  typedef enum logic [3:0]
  {
    CPUOX_OP_NOP,
    CPUOX_OP_MOV_R_IMM,
    CPUOX_OP_MOV_A_R,
    CPUOX_OP_MOV_R_A,
    CPUOX_OP_XCH_A_R,
    CPUOX_OP_MOV_A_IDX,
    CPUOX_OP_MOV_IDX_A,
    CPUOX_OP_XCH_A_IDX,
    CPUOX_OP_MOV_PSW_IMM,
    CPUOX_OP_MOV_PSW_A,
    CPUOX_OP_MOV_A_PSW,
    CPUOX_OP_MOV_SFR_IMM,
    CPUOX_OP_MOV_A_SFR,
    CPUOX_OP_MOV_SFR_A,
    CPUOX_OP_RETI_FLAGS
  } cpuox_op_t;
  typedef enum logic [1:0]
  {
    CPUOX_FL_KEEP,
    CPUOX_FL_FORCE,
    CPUOX_FL_RESULT,
    CPUOX_FL_RESTORE
  } cpuox_flag_t;
  typedef enum logic [1:0]
  {
    CPUOX_ST_IDLE,
    CPUOX_ST_WAIT,
    CPUOX_ST_WRITE
  } cpuox_state_t;
endpackage

// ===== cpuox_addr_check.sv
// Address legality checks for each operand addressing form
`timescale 1ns/1ns
`default_nettype none
`include "cpuox_params.svh"
module cpuox_addr_check
(
  input  wire logic [7:0]  short_op,
  input  wire logic [15:0] abs_addr,
  input  wire logic        abs_word,
  input  wire logic [7:0]  sfr_op,
  input  wire logic        sfr_word,
  input  wire logic [15:0] call_addr,
  input  wire logic [15:0] table_addr,
  output logic      [15:0] short_full,
  output logic             short_byte_ok,
  output logic             short_word_ok,
  output logic             abs_ok,
  output logic             sfr_ok,
  output logic             call_ok,
  output logic             table_ok
);
  // Short operand wraps: 20H..FFH high page FE, 00H..1FH page FF
  always_comb
  begin
    short_full    = (short_op >= 8'h20) ? {8'hFE, short_op} : {8'hFF, short_op};
    short_byte_ok = (short_full >= `CPUOX_SADDR_LO) && (short_full <= `CPUOX_SADDR_HI);
    short_word_ok = short_byte_ok && !short_full[0];
  end
  // Word transfers need even addresses, bytes may land anywhere
  assign abs_ok   = !abs_word || !abs_addr[0];
  // Special register hole is never reachable
  assign sfr_ok   = !(({8'hFF, sfr_op} >= `CPUOX_SFR_HOLE_LO) && ({8'hFF, sfr_op} <= `CPUOX_SFR_HOLE_HI))
                    && (!sfr_word || !sfr_op[0]);
  assign call_ok  = (call_addr >= `CPUOX_CALLF_LO) && (call_addr <= `CPUOX_CALLF_HI);
  assign table_ok = (table_addr >= `CPUOX_CALLT_LO) && (table_addr <= `CPUOX_CALLT_HI)
                    && !table_addr[0];
endmodule
`default_nettype wire

// ===== cpuox_reg_file.sv
// Banked general register file, eight bytes per bank, four banks
`timescale 1ns/1ns
`default_nettype none
module cpuox_reg_file
(
  input  wire logic       clk,
  input  wire logic       nrst,
  input  wire logic       ce,
  input  wire logic [1:0] bank,
  input  wire logic [2:0] rd_sel,
  output logic      [7:0] rd_data,
  output logic      [7:0] acc,
  output logic      [7:0] acc_low,
  input  wire logic [1:0] pr_sel,
  output logic      [7:0] pair_hi,
  output logic      [7:0] pair_lo,
  input  wire logic       wr_en,
  input  wire logic [2:0] wr_sel,
  input  wire logic [7:0] wr_data
);
  logic [7:0] regs [0:31];
  // Flip-flop storage indexed by bank and code
  always_ff @(posedge clk)
  begin
    if (!nrst)
    begin
      for (int i = 0; i < 32; i++)
        regs[i] <= 8'h00;
    end
    else if (ce && wr_en)
      regs[{bank, wr_sel}] <= wr_data;
  end
  // Code 1 is the accumulator, code 0 its low partner of the word pair
  assign rd_data = regs[{bank, rd_sel}];
  assign acc     = regs[{bank, 3'h1}];
  assign acc_low = regs[{bank, 3'h0}];
  // Pair p joins code 2p+1 as high byte and code 2p as low byte
  assign pair_hi = regs[{bank, pr_sel, 1'b1}];
  assign pair_lo = regs[{bank, pr_sel, 1'b0}];
endmodule
`default_nettype wire

// ===== cpuox_exec.sv
// Operand decode and byte move/exchange executor
`timescale 1ns/1ns
`default_nettype none
`include "cpuox_params.svh"
module cpuox_exec
(
  input  wire logic                 clk,
  input  wire logic                 nrst,
  input  wire logic                 ce,
  input  wire logic                 cpu_tick,
  input  wire logic                 start,
  input  wire cpuox_pkg::cpuox_op_t op,
  input  wire logic [2:0]           reg_code,
  input  wire logic [1:0]           pair_code,
  input  wire logic [7:0]           imm,
  input  wire logic [7:0]           sfr_op,
  input  wire logic [7:0]           saved_psw,
  input  wire logic [1:0]           bank_op,
  input  wire logic                 bank_load,
  input  wire logic [2:0]           bit_op,
  input  wire logic [7:0]           rel_disp,
  input  wire logic [15:0]          pc,
  input  wire logic [7:0]           mem_rdata,
  input  wire logic [7:0]           short_op,
  input  wire logic [15:0]          abs_addr,
  input  wire logic                 abs_word,
  input  wire logic [15:0]          call_addr,
  input  wire logic [15:0]          table_addr,
  output logic                      busy,
  output logic                      done,
  output logic [4:0]                clocks,
  output logic [2:0]                bytes,
  output logic                      mem_we,
  output logic [15:0]               mem_addr,
  output logic [7:0]                mem_wdata,
  output logic [7:0]                program_status_word,
  output logic [15:0]               word_accumulator,
  output logic [15:0]               pair_value,
  output logic [7:0]                bit_mask,
  output logic [15:0]               branch_target,
  output logic [15:0]               short_full,
  output logic                      addr_fault
);
  cpuox_pkg::cpuox_state_t state;
  cpuox_pkg::cpuox_op_t    cur_op;
  logic [4:0]  cnt;
  logic [4:0]  next_clocks;
  logic [2:0]  next_bytes;
  logic [7:0]  rd_data;
  logic [7:0]  acc;
  logic [7:0]  acc_low;
  logic [7:0]  pair_hi;
  logic [7:0]  pair_lo;
  logic        rf_we;
  logic [2:0]  rf_sel;
  logic [7:0]  rf_wdata;
  logic [7:0]  latched;
  logic        fast;
  logic        short_byte_ok;
  logic        short_word_ok;
  logic        abs_ok;
  logic        sfr_ok;
  logic        call_ok;
  logic        table_ok;
  cpuox_pkg::cpuox_flag_t flag_mode;

  // Fast RAM test used by the indexed-form timing decisions; special register counts are fixed
  function automatic logic in_fast(input logic [15:0] a);
    in_fast = (a >= `CPUOX_FASTRAM_LO) && (a <= `CPUOX_FASTRAM_HI);
  endfunction

  cpuox_addr_check cpuox_addr_check_i
  (
    .short_op      (short_op),
    .abs_addr      (abs_addr),
    .abs_word      (abs_word),
    .sfr_op        (sfr_op),
    .sfr_word      (1'b0),
    .call_addr     (call_addr),
    .table_addr    (table_addr),
    .short_full    (short_full),
    .short_byte_ok (short_byte_ok),
    .short_word_ok (short_word_ok),
    .abs_ok        (abs_ok),
    .sfr_ok        (sfr_ok),
    .call_ok       (call_ok),
    .table_ok      (table_ok)
  );

  cpuox_reg_file cpuox_reg_file_i
  (
    .clk     (clk),
    .nrst    (nrst),
    .ce      (ce),
    .bank    ({program_status_word[5], program_status_word[3]}),
    .rd_sel  (reg_code),
    .rd_data (rd_data),
    .acc     (acc),
    .acc_low (acc_low),
    .pr_sel  (pair_code),
    .pair_hi (pair_hi),
    .pair_lo (pair_lo),
    .wr_en   (rf_we),
    .wr_sel  (rf_sel),
    .wr_data (rf_wdata)
  );

  // Pair codes 0..3 give word accumulator, BC, DE, index pair, high byte first
  assign pair_value       = {pair_hi, pair_lo};
  assign word_accumulator = {acc, acc_low};

  // Bit mask from 3-bit operand and sign-extended branch target
  assign bit_mask      = 8'h01 << bit_op;
  assign branch_target = pc + {{8{rel_disp[7]}}, rel_disp};
  assign addr_fault    = !(short_byte_ok && abs_ok && sfr_ok && call_ok && table_ok) && start;

  // Memory target of indexed forms: short operand names the index cell
  assign mem_addr = short_full;
  assign fast     = in_fast(mem_addr);

  // Clock and byte counts per operation; slow counts outside fast RAM
  always_comb
  begin
    next_bytes = 3'h1;
    case (op)
      cpuox_pkg::CPUOX_OP_MOV_R_IMM:
      begin
        next_clocks = `CPUOX_CLK_IMM;
        next_bytes  = 3'h2;
      end
      cpuox_pkg::CPUOX_OP_MOV_A_R,
      cpuox_pkg::CPUOX_OP_MOV_R_A,
      cpuox_pkg::CPUOX_OP_XCH_A_R:     next_clocks = `CPUOX_CLK_REG2;
      cpuox_pkg::CPUOX_OP_MOV_A_IDX,
      cpuox_pkg::CPUOX_OP_MOV_IDX_A:
      begin
        next_clocks = fast ? `CPUOX_CLK_IDX_FAST : `CPUOX_CLK_IDX_SLOW;
        next_bytes  = `CPUOX_BYTES_IDX;
      end
      cpuox_pkg::CPUOX_OP_XCH_A_IDX:
      begin
        next_clocks = fast ? `CPUOX_CLK_IDX_FAST : `CPUOX_CLK_XIDX_SLOW;
        next_bytes  = `CPUOX_BYTES_IDX;
      end
      cpuox_pkg::CPUOX_OP_MOV_PSW_IMM,
      cpuox_pkg::CPUOX_OP_MOV_SFR_IMM:
      begin
        next_clocks = `CPUOX_CLK_SFR_IMM;
        next_bytes  = 3'h3;
      end
      cpuox_pkg::CPUOX_OP_MOV_PSW_A,
      cpuox_pkg::CPUOX_OP_MOV_A_PSW,
      cpuox_pkg::CPUOX_OP_MOV_A_SFR,
      cpuox_pkg::CPUOX_OP_MOV_SFR_A:
      begin
        next_clocks = `CPUOX_CLK_SFR_ACC;
        next_bytes  = 3'h2;
      end
      default:                         next_clocks = `CPUOX_CLK_REG2;
    endcase
  end

  // Flag effect class per operation
  always_comb
  begin
    case (cur_op)
      cpuox_pkg::CPUOX_OP_MOV_PSW_IMM,
      cpuox_pkg::CPUOX_OP_MOV_PSW_A:   flag_mode = cpuox_pkg::CPUOX_FL_RESULT;
      cpuox_pkg::CPUOX_OP_RETI_FLAGS:  flag_mode = cpuox_pkg::CPUOX_FL_RESTORE;
      default:                         flag_mode = cpuox_pkg::CPUOX_FL_KEEP;
    endcase
  end

  // Sequencer: counts tick-qualified clocks so one count is one CPU clock period
  always_ff @(posedge clk)
  begin
    if (!nrst)
    begin
      state  <= cpuox_pkg::CPUOX_ST_IDLE;
      cnt    <= 5'h00;
      cur_op <= cpuox_pkg::CPUOX_OP_NOP;
      clocks <= 5'h00;
      bytes  <= 3'h0;
      latched <= 8'h00;
    end
    else if (ce)
    begin
      case (state)
        cpuox_pkg::CPUOX_ST_IDLE:
        begin
          if (start && !addr_fault)
          begin
            state   <= cpuox_pkg::CPUOX_ST_WAIT;
            cur_op  <= op;
            clocks  <= next_clocks;
            bytes   <= next_bytes;
            cnt     <= next_clocks;
            latched <= (op == cpuox_pkg::CPUOX_OP_XCH_A_R) ? rd_data : mem_rdata;
          end
        end
        cpuox_pkg::CPUOX_ST_WAIT:
        begin
          if (cpu_tick)
          begin
            if (cnt == 5'h01)
              state <= cpuox_pkg::CPUOX_ST_WRITE;
            cnt <= cnt - 5'h01;
          end
        end
        cpuox_pkg::CPUOX_ST_WRITE:
          state <= cpuox_pkg::CPUOX_ST_IDLE;
        default:
          state <= cpuox_pkg::CPUOX_ST_IDLE;
      endcase
    end
  end

  assign busy = (state != cpuox_pkg::CPUOX_ST_IDLE);
  assign done = (state == cpuox_pkg::CPUOX_ST_WRITE);

  // Register file write-back in the final cycle; one write port, so a swap writes r early
  always_comb
  begin
    rf_we    = 1'b0;
    rf_sel   = reg_code;
    rf_wdata = acc;
    if (done)
    begin
      case (cur_op)
        cpuox_pkg::CPUOX_OP_MOV_R_IMM:
        begin
          rf_we    = 1'b1;
          rf_wdata = imm;
        end
        cpuox_pkg::CPUOX_OP_MOV_R_A:
          rf_we = 1'b1;
        cpuox_pkg::CPUOX_OP_MOV_A_R:
        begin
          rf_we    = 1'b1;
          rf_sel   = 3'h1;
          rf_wdata = rd_data;
        end
        cpuox_pkg::CPUOX_OP_XCH_A_R,
        cpuox_pkg::CPUOX_OP_MOV_A_IDX,
        cpuox_pkg::CPUOX_OP_XCH_A_IDX,
        cpuox_pkg::CPUOX_OP_MOV_A_SFR:
        begin
          rf_we    = 1'b1;
          rf_sel   = 3'h1;
          rf_wdata = latched;
        end
        cpuox_pkg::CPUOX_OP_MOV_A_PSW:
        begin
          rf_we    = 1'b1;
          rf_sel   = 3'h1;
          rf_wdata = program_status_word;
        end
        default:
          rf_we = 1'b0;
      endcase
    end
    // Old accumulator lands in r on the first counted clock; old r waits in latched
    else if (state == cpuox_pkg::CPUOX_ST_WAIT && cur_op == cpuox_pkg::CPUOX_OP_XCH_A_R && cnt == clocks)
      rf_we = 1'b1;
  end

  // Memory write in the final cycle; exchange writes old accumulator
  assign mem_we    = done && ((cur_op == cpuox_pkg::CPUOX_OP_MOV_IDX_A) ||
                              (cur_op == cpuox_pkg::CPUOX_OP_XCH_A_IDX) ||
                              (cur_op == cpuox_pkg::CPUOX_OP_MOV_SFR_A)  ||
                              (cur_op == cpuox_pkg::CPUOX_OP_MOV_SFR_IMM));
  always_ff @(posedge clk)
  begin
    if (!nrst)
      mem_wdata <= 8'h00;
    else if (ce && start && !addr_fault && state == cpuox_pkg::CPUOX_ST_IDLE)
      mem_wdata <= (op == cpuox_pkg::CPUOX_OP_MOV_SFR_IMM) ? imm : acc;
  end

  // Status word: flags by class; bank field loads directly
  always_ff @(posedge clk)
  begin
    if (!nrst)
      program_status_word <= `CPUOX_PSW_RESET;
    else if (ce)
    begin
      if (bank_load && state == cpuox_pkg::CPUOX_ST_IDLE)
      begin
        program_status_word[5] <= bank_op[1];
        program_status_word[3] <= bank_op[0];
      end
      else if (done)
      begin
        case (flag_mode)
          cpuox_pkg::CPUOX_FL_RESULT:
            program_status_word <= (cur_op == cpuox_pkg::CPUOX_OP_MOV_PSW_IMM) ? imm : acc;
          cpuox_pkg::CPUOX_FL_RESTORE:
            program_status_word <= saved_psw;
          default:
            program_status_word <= program_status_word;
        endcase
      end
    end
  end

  // Checks on timing, flags and addressing
  AST_DONE_AFTER_START: assert property (@(posedge clk) disable iff (!nrst)
    busy && ce |-> ##[0:700] done) else $error("executor never finished");
  AST_REG_TWO: assert property (@(posedge clk) disable iff (!nrst)
    start && !busy && ce && op == cpuox_pkg::CPUOX_OP_MOV_A_R && !addr_fault |=> clocks == 5'h02)
    else $error("register move count wrong");
  AST_IDX_SLOW: assert property (@(posedge clk) disable iff (!nrst)
    start && !busy && ce && op == cpuox_pkg::CPUOX_OP_XCH_A_IDX && !fast && !addr_fault |=> clocks == 5'h0A)
    else $error("exchange slow count wrong");
  AST_IDX_FAST: assert property (@(posedge clk) disable iff (!nrst)
    start && !busy && ce && op == cpuox_pkg::CPUOX_OP_MOV_A_IDX && fast && !addr_fault
    |=> clocks == 5'h08 && bytes == 3'h2)
    else $error("indexed load count wrong");
  AST_SFR_IMM: assert property (@(posedge clk) disable iff (!nrst)
    start && !busy && ce && op == cpuox_pkg::CPUOX_OP_MOV_SFR_IMM && !addr_fault |=> clocks == 5'h07)
    else $error("special immediate count wrong");
  AST_FLAGS_KEEP: assert property (@(posedge clk) disable iff (!nrst)
    done && ce && flag_mode == cpuox_pkg::CPUOX_FL_KEEP && !bank_load |=> $stable(program_status_word))
    else $error("flags changed on plain move");
  AST_RESTORE: assert property (@(posedge clk) disable iff (!nrst)
    done && ce && cur_op == cpuox_pkg::CPUOX_OP_RETI_FLAGS |=> program_status_word == $past(saved_psw))
    else $error("flag restore wrong");
  AST_BRANCH: assert property (@(posedge clk) disable iff (!nrst)
    rel_disp[7] |-> branch_target < pc || pc < 16'h0080)
    else $error("negative displacement not subtracted");
  AST_CALL_RANGE: assert property (@(posedge clk) disable iff (!nrst)
    start && !addr_fault |-> call_addr[15:11] == 5'h01)
    else $error("call address outside window");
  AST_SHORT_EVEN: assert property (@(posedge clk) disable iff (!nrst)
    short_word_ok |-> !short_full[0] && short_full >= 16'hFE20)
    else $error("short word address not even");
  COV_XCH: cover property (@(posedge clk) disable iff (!nrst) done && cur_op == cpuox_pkg::CPUOX_OP_XCH_A_IDX);
  COV_PSW: cover property (@(posedge clk) disable iff (!nrst) done && cur_op == cpuox_pkg::CPUOX_OP_MOV_PSW_IMM);
  COV_FAULT: cover property (@(posedge clk) disable iff (!nrst) addr_fault);
endmodule
`default_nettype wire

// ===== cpu_operand_and_move_exec_tb.sv
// Self-checking bench for the operand decode and byte transfer executor
`timescale 1ns/1ns
`default_nettype none
module cpu_operand_and_move_exec_tb;
  localparam int LIMIT = 20000;
  // Driven inputs and observed outputs; cpu_tick stays high so one counted clock is one clk period
  logic                 clk = 1'b0;
  logic                 nrst = 1'b0;
  logic                 ce = 1'b1;
  logic                 cpu_tick = 1'b1;
  logic                 start = 1'b0;
  logic                 bank_load = 1'b0;
  logic                 abs_word = 1'b1;
  cpuox_pkg::cpuox_op_t op = cpuox_pkg::CPUOX_OP_NOP;
  logic [2:0]           reg_code = 3'h0;
  logic [2:0]           bit_op = 3'h0;
  logic [1:0]           pair_code = 2'h0;
  logic [1:0]           bank_op = 2'h0;
  logic [7:0]           imm = 8'h00;
  logic [7:0]           sfr_op = 8'hCF;
  logic [7:0]           saved_psw = 8'h00;
  logic [7:0]           rel_disp = 8'h00;
  logic [7:0]           mem_rdata = 8'h00;
  logic [7:0]           short_op = 8'h00;
  logic [15:0]          pc = 16'h0000;
  logic [15:0]          abs_addr = 16'h1234;
  logic [15:0]          call_addr = 16'h0FFF;
  logic [15:0]          table_addr = 16'h007E;
  logic                 busy, done, mem_we, addr_fault;
  logic [4:0]           clocks;
  logic [2:0]           bytes;
  logic [7:0]           mem_wdata, program_status_word, bit_mask;
  logic [15:0]          mem_addr, word_accumulator, pair_value, branch_target, short_full;
  // Bench state and reference model of the register banks and status word
  int                   num_errors = 0;
  int                   checked = 0;
  int                   cycles = 0;
  integer               seed = 26;
  logic [7:0]           rg [4][8];
  logic [7:0]           psw_m;
  logic [7:0]           corner [4] = '{8'h00, 8'h1F, 8'h20, 8'hFF};

  cpuox_exec cpuox_exec_i
  (
    .clk, .nrst, .ce, .cpu_tick, .start, .op, .reg_code, .pair_code, .imm, .sfr_op,
    .saved_psw, .bank_op, .bank_load, .bit_op, .rel_disp, .pc, .mem_rdata, .short_op,
    .abs_addr, .abs_word, .call_addr, .table_addr, .busy, .done, .clocks, .bytes,
    .mem_we, .mem_addr, .mem_wdata, .program_status_word, .word_accumulator,
    .pair_value, .bit_mask, .branch_target, .short_full, .addr_fault
  );

  // Clock, 50 ns period
  initial
  begin
    forever #25 clk = ~clk;
  end

  // Hang guard; a stuck handshake ends the run as a failure
  always @(posedge clk)
  begin
    cycles <= cycles + 1;
    if (cycles == LIMIT)
    begin
      num_errors++;
      give_verdict();
    end
  end

  task automatic give_verdict();
    $display("Counts: %0d compared, %0d mismatched", checked, num_errors);
    if (num_errors == 0 && checked > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask

  task automatic cmp(input string what, input logic [15:0] exp, input logic [15:0] got);
    checked++;
    if (got !== exp)
    begin
      num_errors++;
      $display("[ERR] %s expected %h seen %h", what, exp, got);
    end
  endtask

  // Short operand 00..1F folds onto the top of the window, the rest onto FExx
  function automatic logic [15:0] sfull(input logic [7:0] so);
    return {(so < 8'h20) ? 8'hFF : 8'hFE, so};
  endfunction

  // Expected instruction clocks; 1F marks an op whose count is not checked
  function automatic logic [4:0] exp_clk(input cpuox_pkg::cpuox_op_t o, input logic slow);
    case (o)
      cpuox_pkg::CPUOX_OP_MOV_R_IMM: return 5'h04;
      cpuox_pkg::CPUOX_OP_MOV_A_R, cpuox_pkg::CPUOX_OP_MOV_R_A, cpuox_pkg::CPUOX_OP_XCH_A_R: return 5'h02;
      cpuox_pkg::CPUOX_OP_MOV_A_IDX, cpuox_pkg::CPUOX_OP_MOV_IDX_A: return slow ? 5'h09 : 5'h08;
      cpuox_pkg::CPUOX_OP_XCH_A_IDX: return slow ? 5'h0A : 5'h08;
      cpuox_pkg::CPUOX_OP_MOV_PSW_IMM, cpuox_pkg::CPUOX_OP_MOV_SFR_IMM: return 5'h07;
      cpuox_pkg::CPUOX_OP_RETI_FLAGS, cpuox_pkg::CPUOX_OP_NOP: return 5'h1F;
      default: return 5'h05;
    endcase
  endfunction

  task automatic chk_state();
    logic [1:0] bk;
    bk = {psw_m[5], psw_m[3]};
    cmp("status_word", {8'h00, psw_m}, {8'h00, program_status_word});
    cmp("word_accumulator", {rg[bk][1], rg[bk][0]}, word_accumulator);
    cmp("pair_value", {rg[bk][{pair_code, 1'b1}], rg[bk][{pair_code, 1'b0}]}, pair_value);
  endtask

  task automatic reset_run();
    @(posedge clk);
    nrst <= 1'b0;
    repeat (8) @(posedge clk);
    nrst <= 1'b1;
    foreach (rg[i, j]) rg[i][j] = 8'h00;
    psw_m = 8'h02;
    @(negedge clk);
    cmp("busy", 16'h0000, {15'h0000, busy});
    cmp("done", 16'h0000, {15'h0000, done});
    chk_state();
    $display("test reset done");
  endtask

  task automatic set_bank(input logic [1:0] b);
    @(posedge clk);
    bank_op <= b;
    bank_load <= 1'b1;
    @(posedge clk);
    bank_load <= 1'b0;
    psw_m[5] = b[1];
    psw_m[3] = b[0];
    @(negedge clk);
    chk_state();
  endtask

  // One illegal operand per case; the start must be refused and nothing change
  task automatic fault_go(input int k);
    @(posedge clk);
    start <= 1'b1;
    op <= (k > 5) ? cpuox_pkg::CPUOX_OP_MOV_SFR_IMM : cpuox_pkg::CPUOX_OP_MOV_PSW_IMM;
    imm <= ~psw_m;
    abs_addr <= (k == 0) ? 16'h1235 : 16'h1234;
    call_addr <= (k == 1) ? 16'h07FF : (k == 2) ? 16'h1000 : 16'h0FFF;
    table_addr <= (k == 3) ? 16'h0041 : (k == 4) ? 16'h0080 : (k == 5) ? 16'h003E : 16'h007E;
    sfr_op <= (k == 6) ? 8'hD0 : (k == 7) ? 8'hDF : 8'hCF;
    @(negedge clk);
    cmp("addr_fault", 16'h0001, {15'h0000, addr_fault});
    @(posedge clk);
    start <= 1'b0;
    abs_addr <= 16'h1234;
    call_addr <= 16'h0FFF;
    table_addr <= 16'h007E;
    sfr_op <= 8'hCF;
    @(negedge clk);
    cmp("busy_refused", 16'h0000, {15'h0000, busy});
    chk_state();
  endtask

  // Run one op; stall freezes ce early on, poke retries start while busy
  task automatic op_go(input cpuox_pkg::cpuox_op_t o, input logic [2:0] rc, input logic [7:0] im,
                       input logic [7:0] so, input int stall, input bit poke);
    logic [1:0] bk;
    logic [7:0] md;
    logic [7:0] sp;
    logic [7:0] t;
    logic [4:0] ec;
    int         n;
    bk = {psw_m[5], psw_m[3]};
    md = 8'($random(seed));
    sp = 8'($random(seed));
    @(posedge clk);
    start <= 1'b1;
    op <= o;
    reg_code <= rc;
    imm <= im;
    short_op <= so;
    mem_rdata <= md;
    saved_psw <= sp;
    pair_code <= 2'($random(seed));
    bit_op <= 3'($random(seed));
    rel_disp <= 8'($random(seed));
    pc <= 16'($random(seed));
    @(negedge clk);
    cmp("addr_fault_legal", 16'h0000, {15'h0000, addr_fault});
    cmp("bit_mask", {8'h00, 8'h01 << bit_op}, {8'h00, bit_mask});
    cmp("branch_target", pc + {{8{rel_disp[7]}}, rel_disp}, branch_target);
    cmp("short_full", sfull(so), short_full);
    n = 0;
    do
    begin
      @(posedge clk);
      start <= poke && n == 1;
      ce <= n >= stall;
      @(negedge clk);
      n++;
    end
    while (done !== 1'b1 && n < 40);
    ec = exp_clk(o, so < 8'h20);
    cmp("done", 16'h0001, {15'h0000, done});
    if (ec != 5'h1F)
    begin
      cmp("clocks", {11'h000, ec}, {11'h000, clocks});
      cmp("latency", 16'(ec) + 16'(stall) + 16'h0001, 16'(n));
    end
    if (o inside {[cpuox_pkg::CPUOX_OP_MOV_A_IDX : cpuox_pkg::CPUOX_OP_XCH_A_IDX]})
    begin
      cmp("bytes", 16'h0002, {13'h0000, bytes});
      cmp("mem_addr", sfull(so), mem_addr);
      cmp("mem_we", {15'h0000, o != cpuox_pkg::CPUOX_OP_MOV_A_IDX}, {15'h0000, mem_we});
      if (o != cpuox_pkg::CPUOX_OP_MOV_A_IDX)
        cmp("mem_wdata", {8'h00, rg[bk][1]}, {8'h00, mem_wdata});
    end
    else
      cmp("mem_we", {15'h0000, o inside {cpuox_pkg::CPUOX_OP_MOV_SFR_IMM, cpuox_pkg::CPUOX_OP_MOV_SFR_A}},
          {15'h0000, mem_we});
    // Reference model: byte moves and swaps; only status loads touch flags
    t = rg[bk][rc];
    case (o)
      cpuox_pkg::CPUOX_OP_MOV_R_IMM: rg[bk][rc] = im;
      cpuox_pkg::CPUOX_OP_MOV_A_R: rg[bk][1] = t;
      cpuox_pkg::CPUOX_OP_MOV_R_A: rg[bk][rc] = rg[bk][1];
      cpuox_pkg::CPUOX_OP_XCH_A_R:
      begin
        rg[bk][rc] = rg[bk][1];
        rg[bk][1] = t;
      end
      cpuox_pkg::CPUOX_OP_MOV_A_IDX, cpuox_pkg::CPUOX_OP_XCH_A_IDX,
      cpuox_pkg::CPUOX_OP_MOV_A_SFR: rg[bk][1] = md;
      cpuox_pkg::CPUOX_OP_MOV_PSW_IMM: psw_m = im;
      cpuox_pkg::CPUOX_OP_MOV_PSW_A: psw_m = rg[bk][1];
      cpuox_pkg::CPUOX_OP_MOV_A_PSW: rg[bk][1] = psw_m;
      cpuox_pkg::CPUOX_OP_RETI_FLAGS: psw_m = sp;
      default: ;
    endcase
    @(posedge clk);
    start <= 1'b0;
    ce <= 1'b1;
    @(negedge clk);
    cmp("busy_after", 16'h0000, {15'h0000, busy});
    chk_state();
  endtask

  // Main sequence: refusals and corners first, then bank, directed and random traffic, then a second reset
  initial
  begin
    int r;
    reset_run();
    for (int k = 0; k < 8; k++)
      fault_go(k);
    $display("test refusals done");
    for (int k = 0; k < 12; k++)
      op_go(cpuox_pkg::cpuox_op_t'(4'(5 + k % 3)), 3'h0, 8'h00, corner[k / 3], 0, 1'b0);
    op_go(cpuox_pkg::CPUOX_OP_MOV_R_IMM, 3'h1, 8'hA5, 8'h40, 3, 1'b0);
    op_go(cpuox_pkg::CPUOX_OP_MOV_R_IMM, 3'h0, 8'h5A, 8'h40, 0, 1'b1);
    $display("test timing done");
    for (int b = 0; b < 4; b++)
    begin
      set_bank(2'(b));
      op_go(cpuox_pkg::CPUOX_OP_MOV_R_IMM, 3'h1, 8'(b * 16 + 3), 8'h30, 0, 1'b0);
    end
    for (int b = 0; b < 4; b++)
      set_bank(2'(b));
    $display("test banks done");
    for (int k = 1; k < 15; k++)
      if (k != 12)
        op_go(cpuox_pkg::cpuox_op_t'(4'(k)), 3'(k), 8'(k * 37), 8'(k * 19), 0, 1'b0);
    repeat (120)
    begin
      r = 1 + int'($unsigned($random(seed)) % 14);
      if (r == 12)
        r = 2;
      op_go(cpuox_pkg::cpuox_op_t'(4'(r)), 3'($random(seed)), 8'($random(seed)), 8'($random(seed)), 0, 1'b0);
    end
    $display("test random done");
    op_go(cpuox_pkg::CPUOX_OP_MOV_A_SFR, 3'h0, 8'h00, 8'h40, 0, 1'b0);
    reset_run();
    give_verdict();
  end
endmodule
`default_nettype wire
